//--- hdl/blm_defines.vh
// constants for the low-side brake and vds monitor block
`ifndef BLM_DEFINES_VH
`define BLM_DEFINES_VH

// clock rate and time conversion (least times round up)
`define BLM_CLK_MHZ        40
`define BLM_NS2CYC(ns)     (((ns) * `BLM_CLK_MHZ + 999) / 1000)

// brake timing, figures in ns (plain defaults, set per product)
`define BLM_BLANK1_NS      2000
`define BLM_BLANK2_NS      4000
`define BLM_VDS_FILT_NS    1000
`define BLM_OV_FILT_NS     10000
`define BLM_BLANK1_CYC     `BLM_NS2CYC(`BLM_BLANK1_NS)
`define BLM_BLANK2_CYC     `BLM_NS2CYC(`BLM_BLANK2_NS)
`define BLM_VDS_FILT_CYC   `BLM_NS2CYC(`BLM_VDS_FILT_NS)
`define BLM_OV_FILT_CYC    `BLM_NS2CYC(`BLM_OV_FILT_NS)
`define BLM_CNT_W          12

// register byte offsets
`define BLM_OFF_CTRL       12'h000
`define BLM_OFF_DSSTAT     12'h004
`define BLM_OFF_STATE      12'h008
`define BLM_OFF_IRQSTAT    12'h00C
`define BLM_OFF_IRQMASK    12'h010

// control register fields
`define BLM_CTRL_SLAM      0
`define BLM_CTRL_PARK      1
`define BLM_CTRL_OVBR      2
`define BLM_CTRL_VDSTH     3
`define BLM_CTRL_BLANK     4
`define BLM_CTRL_CHARGE_PUMP_ENABLE      5
`define BLM_CTRL_OVCFG_LO  8
`define BLM_CTRL_DIS_LO    16
`define BLM_CTRL_RESET     32'h00000000

// drain-source status fields: [3:0] low-side faults, 4 main, 5 internal
`define BLM_DS_MAIN        4
`define BLM_DS_INT         5
`define BLM_NLS            4
`define BLM_NEV            6

`endif

//--- hdl/blm_brake_monitor.v
// low-side brake control, vds supervision and apb register file
//
// Functional notes
// R1 - slam enabled and pin high: brake
// R2 - parking enabled in sleep/stop: brake
// R3 - overvoltage brake armed in every mode
// R4 - threshold select bit picks vds threshold
// R5 - blank starts at brake, select picks length
// R6 - vds fault ignored while blanking
// R7 - fault needs persistence for filter time
// R8 - fault turns all low sides off, latched
// R9 - fault leaves enable and disable bits alone
// R10 - fault sets per-channel status flag
// R11 - low sides off until all low-side flags cleared
// R12 - charge pump off while any low-side flag set
// R13 - pump enable stored; starts after clear
// R14 - supply overvoltage turns all low sides on
// R15 - overvoltage sets matching supply flag
// R16 - supplies low for filter time: release
// R17 - vds fault ends overvoltage braking too
// R18 - counters on clock; filter restarts on drop
// R19 - software clears flags after fixing cause
`timescale 1ns/1ps
`default_nettype none
`include "blm_defines.vh"

module blm_brake_monitor (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire [31:0] prdata,
   output wire        pslverr,
   // pins and comparators (asynchronous)
   input  wire        slam_input_pin,
   input  wire        vs_ov_cmp,
   input  wire        vsint_ov_cmp,
   input  wire [3:0]  lowside_vds_cmp,
   // device mode from the mode controller (same clock)
   input  wire        sleep_or_stop_mode,
   // gate driver and analog controls
   output wire [3:0]  lowside_on,
   output wire        charge_pump_on,
   output wire        vds_threshold_select,
   output wire [2:0]  ovbr_config,
   // interrupt
   output wire        irq
);

   // address match shared by read and write decode
   function is_reg;
      input [11:0] addr;
      input [11:0] off;
      begin
         is_reg = (addr == off);
      end
   endfunction

   // timer loads are cut to the counter width on purpose
   function [`BLM_CNT_W-1:0] cnt_of;
      input [31:0] cycles;
      begin
         cnt_of = cycles[`BLM_CNT_W-1:0];
      end
   endfunction

   // last count of a timer running up from zero; zero length stays zero
   function [`BLM_CNT_W-1:0] last_of;
      input [31:0] cycles;
      begin
         last_of = (cycles == 32'h00000000) ? {`BLM_CNT_W{1'b0}}
                                            : cycles[`BLM_CNT_W-1:0] - 1'b1;
      end
   endfunction

   // pin to gate: two sync edges plus one register edge
   // so slam trips reach the gates three cycles late, overvoltage trips four through ov_active_r
   // short against the brake turn-on and turn-off times

   // registers
   reg [31:0]           ctrl_r;
   reg [`BLM_NEV-1:0]   dsstat_r;
   reg [`BLM_NEV-1:0]   irqstat_r;
   reg [`BLM_NEV-1:0]   irqmask_r;
   reg                  pready_r;
   reg                  pslverr_r;
   reg [31:0]           prdata_r;
   // synchronisers
   reg                  slam_m_r;
   reg                  slam_s_r;
   reg [1:0]            ov_m_r;
   reg [1:0]            ov_s_r;
   reg [3:0]            vds_m_r;
   reg [3:0]            vds_s_r;
   // brake state
   reg                  ov_active_r;
   reg                  brake_act_d_r;
   reg [`BLM_CNT_W-1:0] blank_cnt_r;
   reg [`BLM_CNT_W-1:0] ovf_cnt_r;
   reg [`BLM_CNT_W-1:0] vf_cnt_r [0:`BLM_NLS-1];
   reg [3:0]            ls_on_r;
   reg                  cp_on_r;
   // filter loop index, kept apart from the detection loop index
   integer              j;

   wire                 slam_en   = ctrl_r[`BLM_CTRL_SLAM];
   wire                 park_en   = ctrl_r[`BLM_CTRL_PARK];
   wire                 ovbr_en   = ctrl_r[`BLM_CTRL_OVBR];
   wire                 blank_sel = ctrl_r[`BLM_CTRL_BLANK];
   wire                 cp_en     = ctrl_r[`BLM_CTRL_CHARGE_PUMP_ENABLE];
   wire [3:0]           slam_dis  = ctrl_r[`BLM_CTRL_DIS_LO+3:`BLM_CTRL_DIS_LO];

   // writable control bits; the rest read back zero
   localparam [31:0]    CTRL_WMASK = (32'h00000001 << `BLM_CTRL_SLAM)
                                   | (32'h00000001 << `BLM_CTRL_PARK)
                                   | (32'h00000001 << `BLM_CTRL_OVBR)
                                   | (32'h00000001 << `BLM_CTRL_VDSTH)
                                   | (32'h00000001 << `BLM_CTRL_BLANK)
                                   | (32'h00000001 << `BLM_CTRL_CHARGE_PUMP_ENABLE)
                                   | (32'h00000007 << `BLM_CTRL_OVCFG_LO)
                                   | (32'h0000000F << `BLM_CTRL_DIS_LO);

   // timer lengths in clock cycles, sized to the counters
   wire [`BLM_CNT_W-1:0] blank1_len = cnt_of(`BLM_BLANK1_CYC);
   wire [`BLM_CNT_W-1:0] blank2_len = cnt_of(`BLM_BLANK2_CYC);
   wire [`BLM_CNT_W-1:0] vds_last   = last_of(`BLM_VDS_FILT_CYC);
   wire [`BLM_CNT_W-1:0] ovf_last   = last_of(`BLM_OV_FILT_CYC);

   // apb qualifiers
   wire                 setup    = psel & ~penable;
   wire                 acc_done = psel & penable & pready_r;
   wire                 wr_done  = acc_done & pwrite;
   wire                 rd_done  = acc_done & ~pwrite;
   // one decode per register, shared by read, write and error logic
   wire                 sel_ctrl  = is_reg(paddr, `BLM_OFF_CTRL);
   wire                 sel_ds    = is_reg(paddr, `BLM_OFF_DSSTAT);
   wire                 sel_state = is_reg(paddr, `BLM_OFF_STATE);
   wire                 sel_irqs  = is_reg(paddr, `BLM_OFF_IRQSTAT);
   wire                 sel_irqm  = is_reg(paddr, `BLM_OFF_IRQMASK);
   wire                 mapped    = sel_ctrl | sel_ds | sel_state | sel_irqs | sel_irqm;
   // strobes at the access edge, where writes and read clears take effect
   wire                 wr_ctrl   = wr_done & sel_ctrl;
   wire                 wr_ds     = wr_done & sel_ds;
   wire                 wr_irqm   = wr_done & sel_irqm;
   wire                 rd_irqs   = rd_done & sel_irqs;

   // brake requests
   wire                 slam_req  = slam_en & slam_s_r;           // R1
   wire                 park_req  = park_en & sleep_or_stop_mode; // R2
   wire                 ov_trip   = ovbr_en & (ov_s_r[0] | ov_s_r[1]); // R3
   wire                 brake_req = slam_req | park_req | ov_active_r;
   wire                 fault_any = |dsstat_r[`BLM_NLS-1:0];
   // a latched fault holds every low side off, disabled ones too
   wire                 brake_act = brake_req & ~fault_any;       // R11
   wire                 brake_start = brake_act & ~brake_act_d_r;
   wire                 blanking  = (blank_cnt_r != {`BLM_CNT_W{1'b0}});

   // slam disable bits only mask channels when slam is the sole cause
   reg  [3:0]           ch_en;
   always @* begin
      ch_en = 4'h0;
      if (park_req | ov_active_r)
         ch_en = 4'hF;
      else if (slam_req)
         ch_en = ~slam_dis;
   end

   // per-channel filter expiry and new fault detection
   // a channel is watched only while driven and past its blank window
   wire [3:0]           mon_armed = ls_on_r & vds_s_r & {4{~blanking}};   // R6
   reg  [3:0]           vds_det;
   integer              i;
   always @* begin
      vds_det = 4'h0;
      for (i = 0; i < `BLM_NLS; i = i + 1) begin
         vds_det[i] = mon_armed[i] & (vf_cnt_r[i] == vds_last);          // R7
      end
   end
   wire                 fault_new = |vds_det;

   // events into the status flags
   wire                 ev_main = ov_trip & ov_s_r[0];                  // R15
   wire                 ev_int  = ov_trip & ov_s_r[1];                  // R15
   wire [`BLM_NEV-1:0]  ev      = {ev_int, ev_main, vds_det};           // R10

   // readable words, zero above the implemented bits
   wire [31:0]          ds_word    = {26'h0000000, dsstat_r};
   wire [31:0]          state_word = {24'h000000, cp_on_r, blanking, ov_active_r,
                                      brake_act, ls_on_r};
   wire [31:0]          irqs_word  = {26'h0000000, irqstat_r};
   wire [31:0]          irqm_word  = {26'h0000000, irqmask_r};

   // pump permission; braking and latched faults both hold it off
   wire                 cp_allow   = cp_en & ~fault_any & ~fault_new & ~brake_act;

   // two-flop synchronisers on every asynchronous input
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slam_m_r <= 1'b0;
         slam_s_r <= 1'b0;
         ov_m_r   <= 2'h0;
         ov_s_r   <= 2'h0;
         vds_m_r  <= 4'h0;
         vds_s_r  <= 4'h0;
      end else begin
         slam_m_r <= slam_input_pin;
         slam_s_r <= slam_m_r;
         ov_m_r   <= {vsint_ov_cmp, vs_ov_cmp};
         ov_s_r   <= ov_m_r;
         vds_m_r  <= lowside_vds_cmp;
         vds_s_r  <= vds_m_r;
      end
   end

   // apb slave: one wait-free access, answer prepared in setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup & ~mapped;
         // read word captured in setup, so the access needs no wait
         if (setup & ~pwrite) begin
            if (sel_ctrl)
               prdata_r <= ctrl_r;
            else if (sel_ds)
               prdata_r <= ds_word;
            else if (sel_state)
               prdata_r <= state_word;
            else if (sel_irqs)
               prdata_r <= irqs_word;
            else if (sel_irqm)
               prdata_r <= irqm_word;
            else
               prdata_r <= 32'h00000000;
         end
      end
   end

   // control and interrupt mask registers; faults never touch them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r    <= `BLM_CTRL_RESET;
         irqmask_r <= {`BLM_NEV{1'b0}};
      end else begin
         // pump enable is stored even while faults are latched
         if (wr_ctrl)
            ctrl_r <= pwdata & CTRL_WMASK;  // R9 R13
         if (wr_irqm)
            irqmask_r <= pwdata[`BLM_NEV-1:0];
      end
   end

   // drain-source status: set by hardware, write one to clear, set wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         dsstat_r <= {`BLM_NEV{1'b0}};
      // a write only clears; an event in the same cycle still sets
      else if (wr_ds)
         dsstat_r <= (dsstat_r & ~pwdata[`BLM_NEV-1:0]) | ev; // R10 R15
      else
         dsstat_r <= dsstat_r | ev;                           // R10 R15
   end

   // interrupt status: cleared by a read, a new event wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irqstat_r <= {`BLM_NEV{1'b0}};
      // clear lands on the access edge, where the master takes the word
      else if (rd_irqs)
         irqstat_r <= ev;
      else
         irqstat_r <= irqstat_r | ev;
   end

   // overvoltage brake: trip immediately, release after the filter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_active_r <= 1'b0;
         ovf_cnt_r   <= {`BLM_CNT_W{1'b0}};
      end else if (!ovbr_en) begin
         ov_active_r <= 1'b0;
         ovf_cnt_r   <= {`BLM_CNT_W{1'b0}};
      end else if (ov_trip) begin
         ov_active_r <= 1'b1;                                 // R14
         ovf_cnt_r   <= {`BLM_CNT_W{1'b0}};
      end else if (ov_active_r) begin
         // comparators carry the hysteresis; both are low here
         // release only after both supplies stayed low this long
         if (ovf_cnt_r == ovf_last) begin
            ov_active_r <= 1'b0;                              // R16
            ovf_cnt_r   <= {`BLM_CNT_W{1'b0}};
         end else begin
            ovf_cnt_r   <= ovf_cnt_r + 1'b1;                  // R18
         end
      end
   end

   // blank timer loaded at each brake activation
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brake_act_d_r <= 1'b0;
         blank_cnt_r   <= {`BLM_CNT_W{1'b0}};
      end else begin
         brake_act_d_r <= brake_act;
         if (brake_start)
            // select is sampled at activation; later writes wait for the next brake
            blank_cnt_r <= blank_sel ? blank2_len : blank1_len; // R5
         else if (!brake_act)
            blank_cnt_r <= {`BLM_CNT_W{1'b0}};
         else if (blanking)
            blank_cnt_r <= blank_cnt_r - 1'b1;                // R18
      end
   end

   // per-channel vds filter; a drop before expiry restarts it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (j = 0; j < `BLM_NLS; j = j + 1)
            vf_cnt_r[j] <= {`BLM_CNT_W{1'b0}};
      end else begin
         for (j = 0; j < `BLM_NLS; j = j + 1) begin
            if (!mon_armed[j] || vds_det[j])
               vf_cnt_r[j] <= {`BLM_CNT_W{1'b0}};             // R6 R18
            else
               vf_cnt_r[j] <= vf_cnt_r[j] + 1'b1;             // R7
         end
      end
   end

   // gate and pump commands; a detection drops all low sides next edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ls_on_r <= 4'h0;
         cp_on_r <= 1'b0;
      end else begin
         // a fresh detection wins over a still-standing brake request
         if (brake_act & ~fault_new)
            ls_on_r <= ch_en;                                 // R1 R2 R14
         else
            ls_on_r <= 4'h0;                                  // R8 R11 R17
         // pump stays off while braking and while faults are latched
         cp_on_r <= cp_allow;                                 // R12 R13
      end
   end

   // outputs
   assign pready               = pready_r;
   assign pslverr              = pslverr_r;
   assign prdata               = prdata_r;
   assign lowside_on           = ls_on_r;
   assign charge_pump_on       = cp_on_r;
   assign vds_threshold_select = ctrl_r[`BLM_CTRL_VDSTH];  // R4
   assign ovbr_config          = ctrl_r[`BLM_CTRL_OVCFG_LO+2:`BLM_CTRL_OVCFG_LO];
   assign irq                  = |(irqstat_r & irqmask_r);

endmodule

`default_nettype wire

//--- verification/blm_gate_model.sv
// gate driver and vds comparator stand-in
`timescale 1ns/1ps
`default_nettype none
module blm_gate_model (
   // gate commands and injected shorts
   input  wire logic [3:0] lowside_on,
   input  wire logic [3:0] short_mask,
   // comparator outputs
   output logic      [3:0] lowside_vds_cmp
);
   // a shorted switch shows high vds only while its gate is driven
   assign lowside_vds_cmp = lowside_on & short_mask;
endmodule
`default_nettype wire

//--- verification/blm_checker.sv
// port assertions for the brake monitor
`timescale 1ns/1ps
`default_nettype none
module blm_checker (
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // brake side
   input wire logic        slam_input_pin,
   input wire logic        vs_ov_cmp,
   input wire logic        vsint_ov_cmp,
   input wire logic [3:0]  lowside_vds_cmp,
   input wire logic        sleep_or_stop_mode,
   input wire logic [3:0]  lowside_on,
   input wire logic        charge_pump_on,
   input wire logic        vds_threshold_select,
   input wire logic [2:0]  ovbr_config
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] vcnt_r;
   logic [5:0] cause_r;
   // run length of high vds on a driven switch, and recent brake causes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vcnt_r  <= 8'h00;
         cause_r <= 6'h00;
      end else begin
         vcnt_r  <= |(lowside_vds_cmp & lowside_on) ? vcnt_r + (vcnt_r != 8'hFF) : 8'h00;
         cause_r <= {cause_r[4:0], slam_input_pin | vs_ov_cmp | vsint_ov_cmp | sleep_or_stop_mode};
      end
   end
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence one_ready;
      pready ##1 !pready;
   endsequence
   ready_pulse_a: assert property (apb_setup |=> one_ready) else $error("pready not one cycle");
   ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
      else $error("error read returned data");
   pump_brake_a: assert property (|lowside_on && $past(|lowside_on) |-> !charge_pump_on)
      else $error("pump on while braking");
   vds_filter_a: assert property (
      $fell(|lowside_on) && $past(|(lowside_vds_cmp & lowside_on)) |-> vcnt_r >= 8'd40)
      else $error("vds fault taken too early");
   brake_cause_a: assert property ($rose(|lowside_on) |-> |cause_r)
      else $error("low side on without cause");
   cfg_write_a: assert property (!$stable({vds_threshold_select, ovbr_config})
      |-> $past(psel && penable && pwrite && paddr == 12'h000)) else $error("config moved");
endmodule
bind blm_brake_monitor blm_checker chk_u (.*);
`default_nettype wire

//--- verification/tb_blm_brake_monitor.sv
// self-checking bench for the brake monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_blm_brake_monitor;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_d;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_d;
   logic        slam_input_pin, vs_ov_cmp, vsint_ov_cmp, sleep_or_stop_mode;
   logic        charge_pump_on, vds_threshold_select, irq;
   logic [3:0]  lowside_vds_cmp, lowside_on, short_mask;
   logic [2:0]  ovbr_config;
   int          mismatches, total_checks, n, s, c, ctl;
   blm_brake_monitor dut_u (.*);
   blm_gate_model gm_u (.lowside_on(lowside_on), .short_mask(short_mask),
      .lowside_vds_cmp(lowside_vds_cmp));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd_d = prdata;
      err_d = pslverr;
      `CHK("pready", 1'b1, pready)
      if (pready !== 1'b1) tally_and_finish;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      `CHK("prdata", ex, rd_d)
   endtask
   // bounded wait for pump and low sides; n gives the cycles taken
   task automatic wait_o(input logic [4:0] ex);
      n = 0;
      while ({charge_pump_on, lowside_on} !== ex && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      `CHK("pump and low sides", ex, {charge_pump_on, lowside_on})
      if ({charge_pump_on, lowside_on} !== ex) tally_and_finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {slam_input_pin, vs_ov_cmp, vsint_ov_cmp, sleep_or_stop_mode, short_mask} = '0;
      mismatches = 0;
      total_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0);
      `CHK("pslverr", 1'b1, err_d)
      apb(1'b1, 12'h008, 32'hFF);
      rd(12'h008, 32'h0);
      apb(1'b1, 12'h010, 32'h3F);
      $display("test registers done");
      // slam brake with channel 0 disabled, fault on channel 1, both blank and threshold
      for (s = 0; s < 2; s++) begin
         ctl = 32'h00010021 | (s * 32'h18);
         apb(1'b1, 12'h000, ctl);
         `CHK("threshold", s[0], vds_threshold_select)
         slam_input_pin <= 1'b1;
         wait_o(5'h0E);
         short_mask <= 4'h2;
         wait_o(5'h00);
         `CHK("fault time", 1'b1, n >= 80 * (s + 1) + 36 && n <= 80 * (s + 1) + 48)
         rd(12'h004, 32'h2);
         rd(12'h000, ctl);
         `CHK("irq", 1'b1, irq)
         rd(12'h00C, 32'h2);
         `CHK("irq clear", 1'b0, irq)
         short_mask <= 4'h0;
         repeat (20) @(posedge pclk);
         `CHK("latched", 5'h00, {charge_pump_on, lowside_on})
         slam_input_pin <= 1'b0;
         repeat (20) @(posedge pclk);
         `CHK("pump held", 1'b0, charge_pump_on)
         apb(1'b1, 12'h004, 32'h2);
         wait_o(5'h10);
      end
      $display("test slam done");
      apb(1'b1, 12'h000, 32'h22);
      sleep_or_stop_mode <= 1'b1;
      wait_o(5'h0F);
      sleep_or_stop_mode <= 1'b0;
      wait_o(5'h10);
      $display("test parking done");
      for (c = 0; c < 8; c++) begin
         apb(1'b1, 12'h000, 32'h24 | (c << 8));
         `CHK("ov config", c[2:0], ovbr_config)
      end
      apb(1'b1, 12'h010, 32'h0);
      for (s = 0; s < 2; s++) begin
         sleep_or_stop_mode <= s[0];
         {vsint_ov_cmp, vs_ov_cmp} <= 2'b01 << s;
         wait_o(5'h0F);
         {vsint_ov_cmp, vs_ov_cmp} <= 2'b00;
         wait_o(5'h10);
         `CHK("release time", 1'b1, n >= 398 && n <= 410)
         rd(12'h004, 32'h10 << s);
         apb(1'b1, 12'h004, 32'h30);
      end
      `CHK("irq masked", 1'b0, irq)
      apb(1'b1, 12'h010, 32'h3F);
      `CHK("irq unmasked", 1'b1, irq)
      rd(12'h00C, 32'h30);
      `CHK("irq read clear", 1'b0, irq)
      vs_ov_cmp  <= 1'b1;
      short_mask <= 4'h4;
      wait_o(5'h00);
      `CHK("ov vds fault time", 1'b1, n >= 120 && n <= 130)
      rd(12'h004, 32'h14);
      short_mask <= 4'h0;
      apb(1'b1, 12'h004, 32'h04);
      wait_o(5'h0F);
      vs_ov_cmp <= 1'b0;
      wait_o(5'h10);
      apb(1'b1, 12'h004, 32'h30);
      $display("test overvoltage done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
